// File: bfft_agent.sv
// Port agent model: free-running port clock and access strobes.
`default_nettype none

module bfft_agent #(
    parameter realtime OFS = 7.0
) (
    input  wire logic       run_i,  // Clock runs while high.
    input  wire logic       en_i,   // Accesses wanted while high.
    input  wire logic       wr_i,   // High write, low read.
    input  wire logic       mb_i,   // Mailbox access.
    input  wire logic [1:0] sz_i,   // Width select, hi then lo.
    output logic            clk_o,  // Port clock pin.
    output logic            cs_n_o, // Chip select, active low.
    output logic            wr_o,   // Write or read pin.
    output logic            mb_o,   // Mailbox select pin.
    output logic      [1:0] sz_o,   // Width select pins.
    output var int          n_o     // Accesses taken.
);
    timeunit 1ns;
    timeprecision 100ps;

    // ========================================================================
    // The clock stays low until released, then runs free at 320 ns.
    initial begin
        clk_o = 1'h0;
        cs_n_o = 1'h1;
        wr_o = 1'h0;
        mb_o = 1'h0;
        sz_o = 2'h0;
        n_o = 0;
        #(OFS);
        forever begin
            #160 clk_o = run_i && !clk_o;
        end
    end

    // Strobes change mid-way between rises; idle qualifiers toggle.
    always @(negedge clk_o) begin
        cs_n_o <= !en_i;
        wr_o   <= en_i ? wr_i : !wr_o;
        mb_o   <= en_i ? mb_i : !mb_o;
        sz_o   <= en_i ? sz_i : ~sz_o;
    end

    // Each rise with chip select low is one access taken.
    always @(posedge clk_o) begin
        if (!cs_n_o) begin
            n_o <= n_o + 1;
        end
    end
endmodule

`default_nettype wire

// File: bfft_pkg.sv
// Constants and types shared by the bidirectional buffer flag block.
// Behaviour
// - Port-B empty rises one port-B cycle after a queue 1 write, else two.
// - At word or byte width, port-B empty falls on the last part read.
// - Port-A empty rises one port-A cycle after a queue 2 write, else two.
// - At word or byte width, queue 2 writes count from the last part.
// - Port-A full rises one port-A cycle after a queue 1 read, else two.
// - At word or byte width, queue 1 reads count from the first part.
// - Port-B full rises one port-B cycle after a queue 2 read, else two.
// - At word or byte width, port-B full falls on the last part write.
// - Port-B almost-empty rises a cycle after passing threshold, else two.
// - Word or byte width: port-B almost-empty falls on first part read.
// - Port-A almost-empty rises a cycle after passing threshold, else two.
// - Port-A almost-empty timing counts from the last part port B writes.
// - Port-A almost-full rises a cycle after leaving threshold, else two.
// - Port-A almost-full timing counts from the first part read on port B.
// - Port-B almost-full rises a cycle after leaving threshold, else two.
// - Word or byte width: port-B almost-full falls on last part write.
// - Both width selects high on a port-B read output the mailbox.
`default_nettype none

package bfft_pkg;

    // ========================================================================
    // Sizes and levels
    localparam int unsigned DATA_W     = 36;
    localparam int unsigned CNT_W      = 7;
    localparam int unsigned NFLAG      = 8;
    localparam logic [6:0] DEPTH_CNT  = 7'h40;  // 64 long words per queue.
    localparam logic [6:0] AE_OFFSET  = 7'h08;  // Almost-empty offset.
    localparam logic [6:0] AF_LEVEL   = 7'h38;  // Depth minus the offset.

    // ========================================================================
    // Flag positions and reset pattern
    // E empty, F full, L almost empty, H almost full.
    localparam int unsigned F_A_E = 0;
    localparam int unsigned F_A_F = 1;
    localparam int unsigned F_A_L = 2;
    localparam int unsigned F_A_H = 3;
    localparam int unsigned F_B_E = 4;
    localparam int unsigned F_B_F = 5;
    localparam int unsigned F_B_L = 6;
    localparam int unsigned F_B_H = 7;
    localparam int unsigned F_A_LAST = 3;       // Flags 0..3 follow port A.
    localparam logic [7:0] FLAG_RST = 8'haa;   // Empty low, full high.

    // ========================================================================
    // Port-B width select codes, {hi, lo}, and last part index
    localparam logic [1:0] SIZ_LONG  = 2'h0;
    localparam logic [1:0] SIZ_BYTE  = 2'h1;
    localparam logic [1:0] SIZ_WORD  = 2'h2;
    localparam logic [1:0] SIZ_MAIL  = 2'h3;
    localparam logic [1:0] LAST_LONG = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h1;
    localparam logic [1:0] LAST_BYTE = 2'h3;
    localparam logic [1:0] PART_RST  = 2'h0;

    typedef enum {
        BFFT_LONG,
        BFFT_WORD,
        BFFT_BYTE,
        BFFT_MAIL
    } bfft_width_e;

    // Port A pin bundle, port clock in bit 0.
    typedef struct packed {
        logic [35:0] data;
        logic        mailbox_select;
        logic        write_read;
        logic        chip_select_n;
        logic        clock;
    } bfft_port_a_s;

    // Port B pin bundle, port clock in bit 0.
    typedef struct packed {
        logic width_select_hi;
        logic width_select_lo;
        logic mailbox_select;
        logic write_read;
        logic chip_select_n;
        logic clock;
    } bfft_port_b_s;

endpackage

`default_nettype wire

// File: bfft_port_sync.sv
// Three-stage pin synchroniser with agreement filter and clock rise pulse.
`default_nettype none

module bfft_port_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,   // System clock.
    input  wire logic         nrst_i,  // Asynchronous reset, active low.
    input  wire logic [W-1:0] async_i, // Pin levels; bit 0 is the port clock.
    output logic      [W-1:0] val_o,   // Accepted pin levels.
    output logic              rise_o   // One-cycle pulse per port clock rise.
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] val_reg;
    logic [W-1:0] val_next;
    logic         rise_reg;
    logic         rise_next;

    // A level is accepted only once the second and third stages agree.
    always_comb begin
        val_next  = (~(s2_reg ^ s3_reg) & s3_reg) |
                    ((s2_reg ^ s3_reg) & val_reg);
        rise_next = val_next[0] & ~val_reg[0];
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            val_reg  <= '0;
            rise_reg <= 1'b0;
        end else begin
            s1_reg   <= async_i;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            val_reg  <= val_next;
            rise_reg <= rise_next;
        end
    end

    assign val_o  = val_reg;
    assign rise_o = rise_reg;

endmodule

`default_nettype wire

// File: bfft_top.sv
// Queue level tracking and flag timing for the two-queue bidirectional buffer.
`default_nettype none

module bfft_top (
    input  wire logic        clk_i,                      // System clock.
    input  wire logic        nrst_i,                     // Reset, active low.
    input  wire logic        port_a_clock_i,             // Port A clock pin.
    input  wire logic        port_a_chip_select_n_i,     // Port A select, low.
    input  wire logic        port_a_write_read_i,        // High write, low read.
    input  wire logic        port_a_mailbox_select_i,    // Port A mailbox.
    input  wire logic [35:0] port_a_data_i,              // Port A data pins.
    input  wire logic        port_b_clock_i,             // Port B clock pin.
    input  wire logic        port_b_chip_select_n_i,     // Port B select, low.
    input  wire logic        port_b_write_read_i,        // High write, low read.
    input  wire logic        port_b_mailbox_select_i,    // Port B mailbox.
    input  wire logic        port_b_width_select_hi_i,   // Width select high.
    input  wire logic        port_b_width_select_lo_i,   // Width select low.
    input  wire logic [35:0] port_b_queue_data_i,        // Queue 1 read word.
    output logic      [35:0] port_b_data_o,              // Port B read data.
    output logic             port_a_empty_flag_o,        // Queue 2 empty, low.
    output logic             port_a_full_flag_o,         // Queue 1 full, low.
    output logic             port_a_almost_empty_flag_o, // Queue 2, low.
    output logic             port_a_almost_full_flag_o,  // Queue 1, low.
    output logic             port_b_empty_flag_o,        // Queue 1 empty, low.
    output logic             port_b_full_flag_o,         // Queue 2 full, low.
    output logic             port_b_almost_empty_flag_o, // Queue 1, low.
    output logic             port_b_almost_full_flag_o,  // Queue 2, low.
    output logic      [6:0]  queue1_level_o,             // Queue 1 long words.
    output logic      [6:0]  queue2_level_o              // Queue 2 long words.
);

    // ========================================================================
    // Pin synchronisers
    bfft_pkg::bfft_port_a_s a_pin;
    bfft_pkg::bfft_port_a_s a_val;
    bfft_pkg::bfft_port_b_s b_pin;
    bfft_pkg::bfft_port_b_s b_val;
    logic                   a_rise;
    logic                   b_rise;

    // Pins are bundled so the strobes stay aligned with their clock edge.
    assign a_pin = '{data:           port_a_data_i,
                     mailbox_select: port_a_mailbox_select_i,
                     write_read:     port_a_write_read_i,
                     chip_select_n:  port_a_chip_select_n_i,
                     clock:          port_a_clock_i};
    assign b_pin = '{width_select_hi: port_b_width_select_hi_i,
                     width_select_lo: port_b_width_select_lo_i,
                     mailbox_select:  port_b_mailbox_select_i,
                     write_read:      port_b_write_read_i,
                     chip_select_n:   port_b_chip_select_n_i,
                     clock:           port_b_clock_i};

    bfft_port_sync #(
        .W ($bits(bfft_pkg::bfft_port_a_s))
    ) u_sync_a (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (a_pin),
        .val_o   (a_val),
        .rise_o  (a_rise)
    );

    bfft_port_sync #(
        .W ($bits(bfft_pkg::bfft_port_b_s))
    ) u_sync_b (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (b_pin),
        .val_o   (b_val),
        .rise_o  (b_rise)
    );

    // ========================================================================
    // Access decode
    logic a_q1_wr;
    logic a_q2_rd;
    logic a_mail_wr;
    logic b_rd;
    logic b_wr;

    // Queue strobes are taken only on an accepted port clock rise.
    assign a_q1_wr   = a_rise & ~a_val.chip_select_n & a_val.write_read &
                       ~a_val.mailbox_select;
    assign a_q2_rd   = a_rise & ~a_val.chip_select_n & ~a_val.write_read &
                       ~a_val.mailbox_select;
    assign a_mail_wr = a_rise & ~a_val.chip_select_n & a_val.write_read &
                       a_val.mailbox_select;
    assign b_rd      = b_rise & ~b_val.chip_select_n & ~b_val.write_read &
                       ~b_val.mailbox_select;
    assign b_wr      = b_rise & ~b_val.chip_select_n & b_val.write_read &
                       ~b_val.mailbox_select;

    bfft_pkg::bfft_width_e b_width;
    logic [1:0]            b_last;

    // Width selects pick long, word, byte or the mailbox path.
    always_comb begin
        case ({b_val.width_select_hi, b_val.width_select_lo})
            bfft_pkg::SIZ_LONG: begin
                b_width = bfft_pkg::BFFT_LONG;
                b_last  = bfft_pkg::LAST_LONG;
            end
            bfft_pkg::SIZ_WORD: begin
                b_width = bfft_pkg::BFFT_WORD;
                b_last  = bfft_pkg::LAST_WORD;
            end
            bfft_pkg::SIZ_BYTE: begin
                b_width = bfft_pkg::BFFT_BYTE;
                b_last  = bfft_pkg::LAST_BYTE;
            end
            default: begin
                b_width = bfft_pkg::BFFT_MAIL;
                b_last  = bfft_pkg::LAST_LONG;
            end
        endcase
    end

    // ========================================================================
    // Queue levels and port-B part counters
    logic [6:0] q1_cnt_reg;
    logic [6:0] q1_cnt_next;
    logic [6:0] q2_cnt_reg;
    logic [6:0] q2_cnt_next;
    logic [1:0] rd_part_reg;
    logic [1:0] rd_part_next;
    logic [1:0] wr_part_reg;
    logic [1:0] wr_part_next;
    logic       b_mail_rd;
    logic       q1_wr_ok;
    logic       q1_rd_ok;
    logic       q1_rd_first;
    logic       q1_rd_last;
    logic       q2_wr_ok;
    logic       q2_commit;
    logic       q2_rd_ok;

    assign b_mail_rd   = b_rd & (b_width == bfft_pkg::BFFT_MAIL);
    assign q1_wr_ok    = a_q1_wr & (q1_cnt_reg != bfft_pkg::DEPTH_CNT);
    assign q1_rd_ok    = b_rd & (b_width != bfft_pkg::BFFT_MAIL) &
                         ((rd_part_reg != bfft_pkg::PART_RST) |
                          (q1_cnt_reg != 7'h00));
    assign q1_rd_first = rd_part_reg == bfft_pkg::PART_RST;
    assign q1_rd_last  = rd_part_reg >= b_last;
    assign q2_wr_ok    = b_wr & (b_width != bfft_pkg::BFFT_MAIL) &
                         ((wr_part_reg != bfft_pkg::PART_RST) |
                          (q2_cnt_reg != bfft_pkg::DEPTH_CNT));
    assign q2_commit   = q2_wr_ok & (wr_part_reg >= b_last);
    assign q2_rd_ok    = a_q2_rd & (q2_cnt_reg != 7'h00);

    // Queue 1 frees a word at its first part; queue 2 fills at its last.
    always_comb begin
        q1_cnt_next  = q1_cnt_reg + {6'h00, q1_wr_ok}
                       - {6'h00, q1_rd_ok & q1_rd_first};
        q2_cnt_next  = q2_cnt_reg + {6'h00, q2_commit}
                       - {6'h00, q2_rd_ok};
        rd_part_next = rd_part_reg;
        if (q1_rd_ok) begin
            rd_part_next = q1_rd_last ? bfft_pkg::PART_RST
                                      : rd_part_reg + 2'h1;
        end
        wr_part_next = wr_part_reg;
        if (q2_wr_ok) begin
            wr_part_next = q2_commit ? bfft_pkg::PART_RST
                                     : wr_part_reg + 2'h1;
        end
    end

    // Level and part registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q1_cnt_reg  <= 7'h00;
            q2_cnt_reg  <= 7'h00;
            rd_part_reg <= bfft_pkg::PART_RST;
            wr_part_reg <= bfft_pkg::PART_RST;
        end else begin
            q1_cnt_reg  <= q1_cnt_next;
            q2_cnt_reg  <= q2_cnt_next;
            rd_part_reg <= rd_part_next;
            wr_part_reg <= wr_part_next;
        end
    end

    // ========================================================================
    // Mailbox and port-B data
    logic [35:0] mail_reg;
    logic [35:0] mail_next;
    logic [35:0] b_data_reg;
    logic [35:0] b_data_next;

    // Mailbox read replaces queue data on the port-B lines.
    always_comb begin
        mail_next   = a_mail_wr ? a_val.data : mail_reg;
        b_data_next = b_data_reg;
        if (b_mail_rd) begin
            b_data_next = mail_reg;
        end else if (q1_rd_ok) begin
            b_data_next = port_b_queue_data_i;
        end
    end

    // Data registers.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mail_reg   <= 36'h0;
            b_data_reg <= 36'h0;
        end else begin
            mail_reg   <= mail_next;
            b_data_reg <= b_data_next;
        end
    end

    // ========================================================================
    // Raw flags, high means not empty, not full or not almost
    logic [7:0] raw_flag;

    always_comb begin
        raw_flag[bfft_pkg::F_A_E] = q2_cnt_reg != 7'h00;
        raw_flag[bfft_pkg::F_A_F] = q1_cnt_reg != bfft_pkg::DEPTH_CNT;
        raw_flag[bfft_pkg::F_A_L] = q2_cnt_reg > bfft_pkg::AE_OFFSET;
        raw_flag[bfft_pkg::F_A_H] = q1_cnt_reg < bfft_pkg::AF_LEVEL;
        raw_flag[bfft_pkg::F_B_E] = (q1_cnt_reg != 7'h00) |
                                    (rd_part_reg != bfft_pkg::PART_RST);
        raw_flag[bfft_pkg::F_B_F] = q2_cnt_reg != bfft_pkg::DEPTH_CNT;
        raw_flag[bfft_pkg::F_B_L] = q1_cnt_reg > bfft_pkg::AE_OFFSET;
        raw_flag[bfft_pkg::F_B_H] = q2_cnt_reg < bfft_pkg::AF_LEVEL;
    end

    // ========================================================================
    // Two-stage flag synchronisers on the owning port's clock rise
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    logic [7:0] stg_reg;
    logic [7:0] stg_next;

    // Port-A flags step on port-A rises, port-B flags on port-B rises.
    for (genvar g = 0; g < bfft_pkg::NFLAG; g++) begin : g_flag
        logic en;
        assign en = (g <= bfft_pkg::F_A_LAST) ? a_rise : b_rise;
        always_comb begin
            stg_next[g]  = en ? raw_flag[g] : stg_reg[g];
            flag_next[g] = en ? stg_reg[g] : flag_reg[g];
        end
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                stg_reg[g]  <= bfft_pkg::FLAG_RST[g];
                flag_reg[g] <= bfft_pkg::FLAG_RST[g];
            end else begin
                stg_reg[g]  <= stg_next[g];
                flag_reg[g] <= flag_next[g];
            end
        end
    end

    // Outputs.
    assign port_a_empty_flag_o        = flag_reg[bfft_pkg::F_A_E];
    assign port_a_full_flag_o         = flag_reg[bfft_pkg::F_A_F];
    assign port_a_almost_empty_flag_o = flag_reg[bfft_pkg::F_A_L];
    assign port_a_almost_full_flag_o  = flag_reg[bfft_pkg::F_A_H];
    assign port_b_empty_flag_o        = flag_reg[bfft_pkg::F_B_E];
    assign port_b_full_flag_o         = flag_reg[bfft_pkg::F_B_F];
    assign port_b_almost_empty_flag_o = flag_reg[bfft_pkg::F_B_L];
    assign port_b_almost_full_flag_o  = flag_reg[bfft_pkg::F_B_H];
    assign port_b_data_o              = b_data_reg;
    assign queue1_level_o             = q1_cnt_reg;
    assign queue2_level_o             = q2_cnt_reg;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Port-A flags move only in the cycle after a port-A rise.
    a_flag_a_edge: assert property (
        $changed(flag_reg[3:0]) |-> $past(a_rise)
    ) else $error("Port-A flag moved without a port-A edge.");

    // Port-B flags move only in the cycle after a port-B rise.
    a_flag_b_edge: assert property (
        $changed(flag_reg[7:4]) |-> $past(b_rise)
    ) else $error("Port-B flag moved without a port-B edge.");

    // A rise of port-B empty follows two port-B edges of a nonempty queue.
    a_bempty_rise: assert property (
        $rose(port_b_empty_flag_o) |-> $past(stg_reg[bfft_pkg::F_B_E])
    ) else $error("Port-B empty rose without a staged level.");

    // Last part read of the last long word clears the raw empty level.
    a_bempty_last: assert property (
        (q1_rd_ok && q1_rd_last && q1_cnt_reg == 7'h00 && !q1_wr_ok)
        |=> !raw_flag[bfft_pkg::F_B_E]
    ) else $error("Empty level held after the last part read.");

    // First part read at the threshold drops the almost-empty level.
    a_blow_first: assert property (
        (q1_rd_ok && q1_rd_first && !q1_wr_ok &&
         q1_cnt_reg == bfft_pkg::AE_OFFSET + 7'h01)
        |=> !raw_flag[bfft_pkg::F_B_L]
    ) else $error("Almost-empty level held after the first part.");

    // Queue 1 level drops by one on a first-part read with no write.
    a_q1_take: assert property (
        (q1_rd_ok && q1_rd_first && !q1_wr_ok)
        |=> q1_cnt_reg == $past(q1_cnt_reg) - 7'h01
    ) else $error("Queue 1 level did not drop on the first part.");

    // A non-final port-B write leaves the queue 2 level untouched.
    a_q2_hold: assert property (
        (q2_wr_ok && !q2_commit && !q2_rd_ok)
        |=> $stable(q2_cnt_reg)
    ) else $error("Queue 2 level moved before the last part.");

    // A final part write to a queue one short of full drops the full level.
    a_bfull_commit: assert property (
        (q2_commit && !q2_rd_ok &&
         q2_cnt_reg == bfft_pkg::DEPTH_CNT - 7'h01)
        |=> !raw_flag[bfft_pkg::F_B_F] ##1 $stable(q2_cnt_reg)[*2]
            or !raw_flag[bfft_pkg::F_B_F]
    ) else $error("Full level held after the completing write.");

    // A mailbox read presents the mailbox word on the next cycle.
    a_mail_out: assert property (
        b_mail_rd |=> port_b_data_o == $past(mail_reg)
    ) else $error("Mailbox read did not output the mailbox.");

    // Scenarios of interest.
    c_q1_full:   cover property (q1_cnt_reg == bfft_pkg::DEPTH_CNT);
    c_byte_read: cover property (q1_rd_ok && q1_rd_last &&
                                 b_width == bfft_pkg::BFFT_BYTE);
    c_word_wr:   cover property (q2_commit &&
                                 b_width == bfft_pkg::BFFT_WORD);
    c_mail_rd:   cover property (b_mail_rd);

endmodule

`default_nettype wire

// File: bfft_top_test.sv
// Self-checking bench for the buffer flag timing block.
`default_nettype none

module bfft_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i = 1'h0;
    logic        nrst_i = 1'h0;
    logic        run = 1'h0;
    logic [1:0]  en = 2'h0, wr = 2'h0, mb = 2'h0, sz = 2'h0;
    logic [35:0] a_data = 36'h0, q_data = 36'h0, b_data;
    logic [7:0]  flags;
    logic [6:0]  lv1, lv2, n2, m1 = 7'h0, m2 = 7'h0;
    logic        pa_clk, pa_cs_n, pa_wr, pa_mb, pb_clk, pb_cs_n, pb_wr, pb_mb;
    logic [1:0]  pb_sz;
    int          na, nb, err_count = 0, num_checks = 0;
    logic [31:0] seed = 32'h684a, r;

    always #20 clk_i = ~clk_i;

    // ========================================================================
    // Two port agents with unrelated phases, and the block itself.
    bfft_agent #(.OFS(7.0)) agent_a (.run_i(run), .en_i(en[0]), .wr_i(wr[0]),
        .mb_i(mb[0]), .sz_i(2'h0), .clk_o(pa_clk), .cs_n_o(pa_cs_n),
        .wr_o(pa_wr), .mb_o(pa_mb), .sz_o(), .n_o(na));
    bfft_agent #(.OFS(131.0)) agent_b (.run_i(run), .en_i(en[1]), .wr_i(wr[1]),
        .mb_i(mb[1]), .sz_i(sz), .clk_o(pb_clk), .cs_n_o(pb_cs_n),
        .wr_o(pb_wr), .mb_o(pb_mb), .sz_o(pb_sz), .n_o(nb));
    bfft_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .port_a_clock_i(pa_clk),
        .port_a_chip_select_n_i(pa_cs_n), .port_a_write_read_i(pa_wr),
        .port_a_mailbox_select_i(pa_mb), .port_a_data_i(a_data),
        .port_b_clock_i(pb_clk), .port_b_chip_select_n_i(pb_cs_n),
        .port_b_write_read_i(pb_wr), .port_b_mailbox_select_i(pb_mb),
        .port_b_width_select_hi_i(pb_sz[1]),
        .port_b_width_select_lo_i(pb_sz[0]), .port_b_queue_data_i(q_data),
        .port_b_data_o(b_data), .port_a_empty_flag_o(flags[0]),
        .port_a_full_flag_o(flags[1]), .port_a_almost_empty_flag_o(flags[2]),
        .port_a_almost_full_flag_o(flags[3]), .port_b_empty_flag_o(flags[4]),
        .port_b_full_flag_o(flags[5]), .port_b_almost_empty_flag_o(flags[6]),
        .port_b_almost_full_flag_o(flags[7]), .queue1_level_o(lv1),
        .queue2_level_o(lv2));

    // Xorshift source of repeatable random values.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected flags from the modelled levels; p marks a half-read word.
    function automatic logic [7:0] ef(input logic p);
        ef[0] = m2 != 7'h0;
        ef[1] = m1 != bfft_pkg::DEPTH_CNT;
        ef[2] = m2 > bfft_pkg::AE_OFFSET;
        ef[3] = m1 < bfft_pkg::AF_LEVEL;
        ef[4] = (m1 != 7'h0) || p;
        ef[5] = m2 != bfft_pkg::DEPTH_CNT;
        ef[6] = m1 > bfft_pkg::AE_OFFSET;
        ef[7] = m2 < bfft_pkg::AF_LEVEL;
    endfunction

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t saw %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Runs n accesses on port p and waits, bounded, for the agent.
    task automatic acc(input int p, input int n, input logic w,
                       input logic m, input logic [1:0] s);
        int start;
        int k;
        start = p ? nb : na;
        en[p] <= 1'h1;
        wr[p] <= w;
        mb[p] <= m;
        sz <= s;
        for (k = 0; k < 9000 && (p ? nb : na) < start + n; k++) begin
            @(posedge clk_i);
        end
        en[p] <= 1'h0;
        repeat (2) @(posedge clk_i);
        if (k == 9000) begin
            err_count++;
            conclude();
        end
    endtask

    // Lets 28 system clocks (three and a half port cycles) pass, then compares levels and flags.
    task automatic vq(input string t, input logic p);
        repeat (28) @(posedge clk_i);
        check({29'h0, lv1}, {29'h0, m1});
        check({29'h0, lv2}, {29'h0, m2});
        check({28'h0, flags}, {28'h0, ef(p)});
        $display("test %s done", t);
    endtask

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'h1;
        vq("reset", 1'h0);
        check({28'h0, flags}, {28'h0, bfft_pkg::FLAG_RST});
        run <= 1'h1;
        acc(0, 9, 1'h1, 1'h0, 2'h0);
        m1 = 7'h9;
        vq("queue 1 fill", 1'h0);
        r = rnd();
        q_data <= {r[3:0], r};
        acc(1, 1, 1'h0, 1'h0, bfft_pkg::SIZ_BYTE);
        m1 = 7'h8;
        vq("first byte", 1'h1);
        acc(1, 3, 1'h0, 1'h0, bfft_pkg::SIZ_BYTE);
        acc(1, 15, 1'h0, 1'h0, bfft_pkg::SIZ_WORD);
        m1 = 7'h0;
        vq("half word left", 1'h1);
        acc(1, 1, 1'h0, 1'h0, bfft_pkg::SIZ_WORD);
        vq("last word", 1'h0);
        check(b_data, q_data);
        r = rnd();
        n2 = 7'h9 + {4'h0, r[2:0]};
        acc(1, 2 * int'(n2) - 1, 1'h1, 1'h0, bfft_pkg::SIZ_WORD);
        m2 = n2 - 7'h1;
        vq("queue 2 part", 1'h0);
        acc(1, 1, 1'h1, 1'h0, bfft_pkg::SIZ_WORD);
        m2 = n2;
        vq("queue 2 words", 1'h0);
        acc(1, 2 * (64 - int'(n2)) - 1, 1'h1, 1'h0, bfft_pkg::SIZ_WORD);
        m2 = 7'h3f;
        vq("queue 2 nearly", 1'h0);
        acc(1, 2, 1'h1, 1'h0, bfft_pkg::SIZ_WORD);
        m2 = 7'h40;
        vq("queue 2 full", 1'h0);
        acc(0, 9, 1'h0, 1'h0, 2'h0);
        m2 = 7'h37;
        vq("queue 2 drain", 1'h0);
        acc(0, 65, 1'h1, 1'h0, 2'h0);
        m1 = 7'h40;
        vq("queue 1 full", 1'h0);
        acc(1, 1, 1'h0, 1'h0, bfft_pkg::SIZ_BYTE);
        m1 = 7'h3f;
        vq("full freed", 1'h1);
        acc(1, 3, 1'h0, 1'h0, bfft_pkg::SIZ_BYTE);
        acc(1, 8, 1'h0, 1'h0, bfft_pkg::SIZ_LONG);
        m1 = 7'h37;
        vq("almost full freed", 1'h0);
        r = rnd();
        a_data <= {r[7:4], r};
        acc(0, 1, 1'h1, 1'h1, 2'h0);
        acc(1, 1, 1'h0, 1'h0, bfft_pkg::SIZ_MAIL);
        // The read is taken only after the pin synchroniser delay.
        repeat (6) @(posedge clk_i);
        check(b_data, a_data);
        $display("test mailbox done");
        conclude();
    end
endmodule

`default_nettype wire
